// ==== src/slave_state_control.sv ====
// Purpose: slave state machine, process-traffic watchdog, dictionary decode
// Assumes: one 100 MHz clock, synchronous active-high reset, APB slave
// Notes: outputs are all registered; state struct holds every flop
//
// Our own choices: the APB slave port and the register offsets.
`include "slave_ctrl_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module slave_state_control
  import slave_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // traffic from the bus controller
  input wire logic mbx_req,
  input wire logic mbx_is_file,
  input wire logic pd_access,
  input wire logic [15:0] pd_out_data,
  input wire logic [15:0] in_values,
  // gates and results
  output logic mbx_allow,
  output logic pd_allow,
  output logic [15:0] out_drive,
  output logic [15:0] shared_in,
  output logic wd_expired,
  // non-volatile store request
  output logic nv_save,
  output logic [15:0] nv_index,
  output logic [7:0] nv_sub,
  output logic [31:0] nv_data
);

  // last count of the fast-clock divider: four cycles per 40 ns base tick
  localparam logic [1:0] BASE_DIV = 2'(`CYC_PER_BASE - 1);

  // all state of the block
  // one packed struct keeps reset and next-state handling in one place
  typedef struct packed {
    slave_state_t st;
    logic [15:0] wd_mult;
    logic [15:0] wd_count;
    logic [1:0] base_cnt;
    logic [17:0] tick_cnt;
    logic [15:0] wd_cnt;
    logic wd_active;
    logic wd_expired;
    logic mbx_ok;
    logic pd_ok;
    logic dc_used;
    logic dc_ok;
    logic req_refused;
    logic [15:0] dict_idx;
    logic [7:0] dict_sub;
    logic nosave;
    logic [31:0] nosave_word;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic mbx_allow;
    logic pd_allow;
    logic [15:0] out_drive;
    logic [15:0] shared_in;
    logic nv_save;
    logic [31:0] nv_data;
  } state_t;

  state_t s_q; // registered state
  state_t s_d; // next state

  // decode an index to its dictionary region
  // apart from the exact nosave index, only the top nibble is decoded, so every index of a range maps alike
  function automatic dict_region_t region_of(input logic [15:0] idx);
    if (idx == `IDX_NOSAVE) begin
      return rg_nosave;
    end else if (idx[15:12] == `IDX_IDENTITY >> 12) begin
      return rg_identity;
    end else if (idx[15:12] == `IDX_CHAN >> 12 || idx[15:12] == `IDX_CHAN_ALT >> 12) begin
      return rg_chan;
    end else if (idx[15:12] == `IDX_INPUTS >> 12) begin
      return rg_inputs;
    end else if (idx[15:12] == `IDX_OUTPUTS >> 12) begin
      return rg_outputs;
    end else begin
      return rg_none;
    end
  endfunction

  // channel number of a channel-range index: sixteen indices each
  function automatic logic [7:0] chan_of(input logic [15:0] idx);
    return idx[11:4];
  endfunction

  // apb phase qualifiers; pready is a one-cycle registered pulse, and
  // masking the access with it stops a held access phase being taken twice
  logic apb_acc;
  logic apb_wr;
  logic apb_rd;
  assign apb_acc = psel && penable && !s_q.pready;
  assign apb_wr = apb_acc && pwrite;
  assign apb_rd = apb_acc && !pwrite;

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.nv_save = 1'b0;

    // base tick divider and watchdog tick: (mult + 2) base periods
    // limitation: the countdown also runs outside the process data states;
    // an expiry left over from there clears on the first allowed access
    if (s_q.base_cnt == BASE_DIV) begin
      s_d.base_cnt = '0;
      if (s_q.tick_cnt >= {2'b00, s_q.wd_mult} + `WD_EXTRA - 18'h00001) begin
        s_d.tick_cnt = '0;
        if (s_q.wd_active && s_q.wd_cnt != '0) begin
          s_d.wd_cnt = s_q.wd_cnt - 16'h0001;
          if (s_q.wd_cnt == 16'h0001) begin
            s_d.wd_expired = 1'b1;
          end
        end
      end else begin
        s_d.tick_cnt = s_q.tick_cnt + 18'h00001;
      end
    end else begin
      s_d.base_cnt = s_q.base_cnt + 2'b01;
    end

    // each allowed process access restarts the watchdog
    if (pd_access && s_q.pd_allow) begin
      s_d.wd_cnt = s_q.wd_count;
      s_d.tick_cnt = '0;
      s_d.wd_expired = 1'b0;
    end
    // zero count switches monitoring off
    // the enable follows the count one cycle late, which only delays a trip
    s_d.wd_active = (s_q.wd_count != '0);
    if (!s_q.wd_active) begin
      s_d.wd_expired = 1'b0;
    end

    // register writes
    // a refused state request keeps the state and flags the status word
    if (apb_wr) begin
      s_d.pready = 1'b1;
      unique case (paddr)
        `REG_STATE_REQ: begin
          s_d.req_refused = 1'b1;
          unique case (pwdata[2:0])
            `REQ_INIT: begin
              s_d.st = st_init;
              s_d.req_refused = 1'b0;
            end
            `REQ_CONFIG: begin
              if ((s_q.st == st_init && s_q.mbx_ok) || s_q.st == st_inputs
                  || s_q.st == st_running) begin
                s_d.st = st_config;
                s_d.req_refused = 1'b0;
              end
            end
            `REQ_BOOT: begin
              if (s_q.st == st_init && s_q.mbx_ok) begin
                s_d.st = st_boot;
                s_d.req_refused = 1'b0;
              end
            end
            `REQ_INPUTS: begin
              if ((s_q.st == st_config && s_q.pd_ok && (!s_q.dc_used || s_q.dc_ok))
                  || s_q.st == st_running) begin
                s_d.st = st_inputs;
                s_d.shared_in = in_values;
                s_d.req_refused = 1'b0;
              end
            end
            `REQ_RUN: begin
              if (s_q.st == st_inputs) begin
                s_d.st = st_running;
                s_d.req_refused = 1'b0;
              end
            end
            default: begin
              s_d.req_refused = 1'b1;
            end
          endcase
        end
        `REG_WD_MULT: s_d.wd_mult = pwdata[15:0];
        `REG_WD_COUNT: begin
          s_d.wd_count = pwdata[15:0];
          s_d.wd_cnt = pwdata[15:0];
        end
        `REG_MBX_CFG: s_d.mbx_ok = pwdata[0];
        `REG_PD_CFG: begin
          s_d.pd_ok = pwdata[0];
          s_d.dc_used = pwdata[1];
          s_d.dc_ok = pwdata[2];
        end
        `REG_DICT_ADDR: begin
          s_d.dict_idx = pwdata[15:0];
          s_d.dict_sub = pwdata[23:16];
        end
        `REG_DICT_DATA: begin
          if (region_of(s_q.dict_idx) == rg_nosave) begin
            s_d.nosave_word = pwdata;
            s_d.nosave = (pwdata == `NOSAVE_CODE);
          end else if (region_of(s_q.dict_idx) == rg_none
                       || region_of(s_q.dict_idx) == rg_identity) begin
            s_d.pslverr = 1'b1; // identity is read only
            // a standing code word suppresses the store pulse
          end else if (!s_q.nosave) begin
            s_d.nv_save = 1'b1;
            s_d.nv_data = pwdata;
          end
        end
        default: s_d.pslverr = 1'b1;
      endcase
    end

    // register reads
    // read data stays in its flop until the next read, so a slow master still sees it
    if (apb_rd) begin
      s_d.pready = 1'b1;
      unique case (paddr)
        `REG_STATE_REQ: s_d.prdata = {29'h0, s_q.st};
        `REG_STATUS: s_d.prdata = {25'h0, s_q.nosave, s_q.req_refused, s_q.wd_expired,
                                  s_q.wd_active, s_q.st};
        `REG_WD_MULT: s_d.prdata = {16'h0, s_q.wd_mult};
        `REG_WD_COUNT: s_d.prdata = {16'h0, s_q.wd_count};
        `REG_MBX_CFG: s_d.prdata = {31'h0, s_q.mbx_ok};
        `REG_PD_CFG: s_d.prdata = {29'h0, s_q.dc_ok, s_q.dc_used, s_q.pd_ok};
        `REG_DICT_ADDR: s_d.prdata = {8'h0, s_q.dict_sub, s_q.dict_idx};
        `REG_DICT_DATA: s_d.prdata = s_q.nosave_word;
        `REG_CHAN_BASE: s_d.prdata = {21'h0, region_of(s_q.dict_idx), chan_of(s_q.dict_idx)};
        default: begin
          s_d.prdata = 32'h00000000;
          s_d.pslverr = 1'b1;
        end
      endcase
    end

    // traffic gates per state
    // gates follow the next state so they open on the edge the state changes
    unique case (s_d.st)
      st_init: begin
        s_d.mbx_allow = 1'b0;
        s_d.pd_allow = 1'b0;
      end
      st_config: begin
        s_d.mbx_allow = 1'b1;
        s_d.pd_allow = 1'b0;
      end
      st_inputs, st_running: begin
        s_d.mbx_allow = 1'b1;
        s_d.pd_allow = 1'b1;
      end
      st_boot: begin
        s_d.mbx_allow = mbx_req && mbx_is_file;
        s_d.pd_allow = 1'b0;
      end
    endcase

    // inputs refreshed every cycle while process data runs
    if (s_q.st == st_inputs || s_q.st == st_running) begin
      s_d.shared_in = in_values;
    end

    // outputs: driven in running, or in inputs-only without monitoring
    // an expiry outranks every state: safe outputs come first
    if (s_q.wd_active && s_q.wd_expired) begin
      s_d.out_drive = '0;
    end else if (s_q.st == st_running) begin
      s_d.out_drive = pd_out_data;
    end else if (s_q.st == st_inputs && !s_q.wd_active) begin
      s_d.out_drive = pd_out_data;
    end else begin
      s_d.out_drive = '0;
    end
  end

  // single state register, synchronous reset
  // monitoring starts active with the default tick and count
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= st_init;
      s_q.wd_mult <= `WD_MULT_RESET;
      s_q.wd_count <= `WD_COUNT_RESET;
      s_q.wd_cnt <= `WD_COUNT_RESET;
      s_q.wd_active <= 1'b1;
      s_q.nosave <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ports straight from flops
  // store index and subindex come straight from the dictionary address
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign mbx_allow = s_q.mbx_allow;
  assign pd_allow = s_q.pd_allow;
  assign out_drive = s_q.out_drive;
  assign shared_in = s_q.shared_in;
  assign wd_expired = s_q.wd_expired;
  assign nv_save = s_q.nv_save;
  assign nv_index = s_q.dict_idx;
  assign nv_sub = s_q.dict_sub;
  assign nv_data = s_q.nv_data;

endmodule

`default_nettype wire

// ==== src/slave_ctrl_defines.svh ====
// Purpose: constants for the fieldbus slave state control block
// Assumes: 100 MHz clock, 32-bit APB data
// Notes: register offsets are byte addresses
`ifndef SLAVE_CTRL_DEFINES_SVH
`define SLAVE_CTRL_DEFINES_SVH

// register byte offsets
`define REG_STATE_REQ 12'h000
`define REG_STATUS 12'h004
`define REG_WD_MULT 12'h008
`define REG_WD_COUNT 12'h00C
`define REG_MBX_CFG 12'h010
`define REG_PD_CFG 12'h014
`define REG_DICT_ADDR 12'h018
`define REG_DICT_DATA 12'h01C
`define REG_CHAN_BASE 12'h020

// watchdog figures
`define BASE_CLK_MHZ 25
`define SYS_CLK_MHZ 100
`define CYC_PER_BASE (`SYS_CLK_MHZ / `BASE_CLK_MHZ)
`define WD_MULT_RESET 16'h09C2
`define WD_COUNT_RESET 16'h03E8
`define WD_EXTRA 18'h00002

// dictionary ranges and code word
`define IDX_IDENTITY 16'h1000
`define IDX_CHAN_ALT 16'h4000
`define IDX_INPUTS 16'h6000
`define IDX_OUTPUTS 16'h7000
`define IDX_CHAN 16'h8000
`define IDX_CHAN_STEP 16'h0010
`define IDX_NOSAVE 16'hF008
`define NOSAVE_CODE 32'h12345678

// state request codes
`define REQ_INIT 3'h1
`define REQ_CONFIG 3'h2
`define REQ_BOOT 3'h3
`define REQ_INPUTS 3'h4
`define REQ_RUN 3'h5

`endif

// ==== src/slave_ctrl_pkg.sv ====
// Purpose: types for the fieldbus slave state control block
// Assumes: nothing beyond the defines header
// Notes: holds types only
package slave_ctrl_pkg;
  typedef enum logic [2:0] {
    st_init,
    st_config,
    st_inputs,
    st_running,
    st_boot
  } slave_state_t;

  typedef enum logic [2:0] {
    rg_none,
    rg_identity,
    rg_chan,
    rg_inputs,
    rg_outputs,
    rg_nosave
  } dict_region_t;
endpackage

// ==== bench/slave_ctrl_asserts.sv ====
// Purpose: port-level checks for the slave state control block
// Assumes: one clock, synchronous active-high reset
// Notes: attached by bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module slave_ctrl_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // traffic and gates
  input wire logic pd_access,
  input wire logic mbx_allow,
  input wire logic pd_allow,
  input wire logic [15:0] out_drive,
  input wire logic wd_expired,
  input wire logic nv_save,
  input wire logic [15:0] nv_index
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // two cycles with exchange shut, so gate and drive flops have settled
  sequence shut_s;
    !pd_allow ##1 !pd_allow;
  endsequence
  reset_quiet_a: assert property ($fell(rst) |-> !mbx_allow && !pd_allow && !pready)
    else $error("gates open right after reset");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_cause_a: assert property (pready |-> $past(psel) && $past(penable))
    else $error("ready without access phase");
  data_needs_mbx_a: assert property (pd_allow |-> mbx_allow)
    else $error("process data open with mailbox shut");
  shut_safe_a: assert property (shut_s |-> out_drive == 16'h0000)
    else $error("outputs driven while exchange shut");
  expiry_clears_a: assert property ($rose(wd_expired) |-> ##[0:2] out_drive == 16'h0000)
    else $error("outputs kept after expiry");
  access_rearm_a: assert property (pd_access && pd_allow |-> ##1 !wd_expired)
    else $error("expiry kept after access");
  code_not_saved_a: assert property (nv_save |-> nv_index != 16'hF008)
    else $error("code word entry saved");
endmodule
bind slave_state_control slave_ctrl_asserts u_chk (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .pd_access(pd_access),
  .mbx_allow(mbx_allow), .pd_allow(pd_allow), .out_drive(out_drive),
  .wd_expired(wd_expired), .nv_save(nv_save), .nv_index(nv_index));
`default_nettype wire

// ==== bench/fieldbus_master_model.sv ====
// Purpose: far-side master issuing cyclic process data accesses
// Assumes: bench turns cyclic traffic on and off
// Notes: output word is fixed and valid before running is asked
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master_model #(
  parameter logic [15:0] OUT_WORD = 16'hA5C3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench control
  input wire logic cyclic_on,
  // traffic toward the block
  output logic pd_access,
  output logic [15:0] pd_out_data
);
  logic [2:0] gap_q; // cycles since last access
  // one access every eight cycles, well inside any test monitoring time
  always_ff @(posedge clk) begin
    if (rst) begin
      gap_q <= 3'h0;
      pd_access <= 1'b0;
    end else begin
      gap_q <= gap_q + 3'h1;
      pd_access <= cyclic_on && (gap_q == 3'h7);
    end
  end
  assign pd_out_data = OUT_WORD;
endmodule
`default_nettype wire

// ==== bench/fieldbus_slave_state_control_test.sv ====
// Purpose: directed bench for the slave state control block
// Assumes: 100 MHz clock, apb slave answers after one wait cycle
// Notes: watchdog shortened by writing small multiplier and count
`timescale 1ns/1ps
`default_nettype none
`include "slave_ctrl_defines.svh"
module fieldbus_slave_state_control_test;
  import slave_ctrl_pkg::*;
  logic clk, rst, psel, penable, pwrite, mbx_req, mbx_is_file, pd_access, cyclic_on, err;
  logic pready, pslverr, mbx_allow, pd_allow, wd_expired, nv_save;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, nv_data;
  logic [15:0] pd_out_data, in_values, out_drive, shared_in, nv_index;
  logic [7:0] nv_sub;
  logic [23:0] last_key; // sub and index of last store
  int fails, n_checks, saves, k;
  logic [15:0] idx_tab [7] = '{16'h0000, 16'h1000, 16'h8010, 16'h4020, 16'h6000, 16'h7000,
    16'hF008};
  dict_region_t reg_tab [7] = '{rg_none, rg_identity, rg_chan, rg_chan, rg_inputs,
    rg_outputs, rg_nosave};
  slave_state_control uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mbx_req(mbx_req), .mbx_is_file(mbx_is_file), .pd_access(pd_access),
    .pd_out_data(pd_out_data), .in_values(in_values), .mbx_allow(mbx_allow),
    .pd_allow(pd_allow), .out_drive(out_drive), .shared_in(shared_in),
    .wd_expired(wd_expired), .nv_save(nv_save), .nv_index(nv_index), .nv_sub(nv_sub),
    .nv_data(nv_data));
  fieldbus_master_model peer (.clk(clk), .rst(rst), .cyclic_on(cyclic_on),
    .pd_access(pd_access), .pd_out_data(pd_out_data));
  // 10 ns clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // store pulses last one cycle, so catch them here
  always @(posedge clk) begin
    if (nv_save === 1'b1) begin
      saves <= saves + 1;
      last_key <= {nv_sub, nv_index};
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one apb transfer; an idle edge first keeps drives one per time step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 40) begin
      chk("pready", 32'h1, 32'h0);
      conclude();
    end
  endtask
  task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  task automatic req(input logic [2:0] code, input slave_state_t exp);
    apb(1'b1, `REG_STATE_REQ, {29'h0, code});
    rdc("state", `REG_STATE_REQ, {29'h0, exp});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    conclude();
  end
  initial begin
    {rst, psel, penable, pwrite, mbx_req, mbx_is_file, cyclic_on} = 7'h41;
    paddr = 12'h000;
    pwdata = 32'h0;
    in_values = 16'h3C5A;
    idle(20);
    rst <= 1'b0;
    chk("gates", 32'h0, {30'h0, mbx_allow, pd_allow});
    rdc("mult", `REG_WD_MULT, 32'h000009C2);
    rdc("count", `REG_WD_COUNT, 32'h000003E8);
    req(`REQ_CONFIG, st_init);
    rdc("status", `REG_STATUS, 32'h00000028);
    req(`REQ_BOOT, st_init);
    req(`REQ_RUN, st_init);
    apb(1'b1, `REG_MBX_CFG, 32'h1);
    req(`REQ_CONFIG, st_config);
    chk("gates", 32'h2, {30'h0, mbx_allow, pd_allow});
    req(`REQ_BOOT, st_config);
    apb(1'b1, `REG_PD_CFG, 32'h2);
    req(`REQ_INPUTS, st_config);
    apb(1'b1, `REG_PD_CFG, 32'h7);
    req(`REQ_INPUTS, st_inputs);
    chk("shared", {16'h0, in_values}, {16'h0, shared_in});
    chk("drive", 32'h00030000, {14'h0, mbx_allow, pd_allow, out_drive});
    cyclic_on <= 1'b1;
    req(`REQ_RUN, st_running);
    idle(4);
    chk("drive", 32'hA5C3, {16'h0, out_drive});
    in_values <= 16'hC33C;
    idle(3);
    chk("shared", 32'h0000C33C, {16'h0, shared_in});
    apb(1'b1, `REG_WD_MULT, 32'h1);
    apb(1'b1, `REG_WD_COUNT, 32'h2);
    idle(60);
    chk("expired", 32'h0, {31'h0, wd_expired});
    cyclic_on <= 1'b0;
    // two ticks of twelve cycles: no trip earlier than some 16 cycles from here
    idle(12);
    chk("expired", 32'h0, {31'h0, wd_expired});
    idle(32);
    chk("expired", 32'h00010000, {15'h0, wd_expired, out_drive});
    rdc("state", `REG_STATE_REQ, {29'h0, st_running});
    apb(1'b1, `REG_WD_COUNT, 32'h0);
    cyclic_on <= 1'b1;
    idle(12);
    cyclic_on <= 1'b0;
    idle(100);
    chk("expired", 32'h0, {31'h0, wd_expired});
    chk("drive", 32'hA5C3, {16'h0, out_drive});
    req(`REQ_INPUTS, st_inputs);
    chk("drive", 32'hA5C3, {16'h0, out_drive});
    req(`REQ_INIT, st_init);
    req(`REQ_BOOT, st_boot);
    mbx_req <= 1'b1;
    mbx_is_file <= 1'b1;
    idle(3);
    chk("gates", 32'h2, {30'h0, mbx_allow, pd_allow});
    mbx_is_file <= 1'b0;
    idle(3);
    chk("gates", 32'h0, {30'h0, mbx_allow, pd_allow});
    req(`REQ_INIT, st_init);
    for (k = 0; k < 7; k++) begin
      apb(1'b1, `REG_DICT_ADDR, {8'h0, 8'hFF, idx_tab[k]});
      rdc("region", `REG_CHAN_BASE, {21'h0, reg_tab[k], idx_tab[k][11:4]});
    end
    apb(1'b1, `REG_DICT_ADDR, 32'h00078010);
    apb(1'b1, `REG_DICT_DATA, 32'h0000BEEF);
    idle(2);
    chk("store", 32'h01078010, {saves[7:0], last_key});
    chk("data", 32'h0000BEEF, nv_data);
    apb(1'b1, `REG_DICT_ADDR, {16'h0, `IDX_NOSAVE});
    apb(1'b1, `REG_DICT_DATA, `NOSAVE_CODE);
    rdc("code", `REG_DICT_DATA, `NOSAVE_CODE);
    apb(1'b1, `REG_DICT_ADDR, 32'h00078010);
    apb(1'b1, `REG_DICT_DATA, 32'h00001234);
    idle(2);
    chk("store", 32'h1, saves);
    apb(1'b1, `REG_DICT_ADDR, {16'h0, `IDX_NOSAVE});
    apb(1'b1, `REG_DICT_DATA, 32'h0);
    apb(1'b1, `REG_DICT_ADDR, 32'h00078010);
    apb(1'b1, `REG_DICT_DATA, 32'h00005678);
    idle(2);
    chk("store", 32'h2, saves);
    apb(1'b1, `REG_DICT_ADDR, {16'h0, `IDX_IDENTITY});
    apb(1'b1, `REG_DICT_DATA, 32'h1);
    chk("refuse", 32'h1, {31'h0, err});
    apb(1'b0, 12'h0FC, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
    conclude();
  end
endmodule
`default_nettype wire
